/* arc_pkg.sv */
// shared constants, types and register map of the result computation block
// Contract
// R01 - add or subtract sample, flag overflow
// R02 - count each accumulated sample, repeat target
// R03 - clear command zeroes accumulator, flag, counter
// R04 - clearing finishes within five converter clocks
// R05 - filtered result is accumulator shifted right
// R06 - basic mode: no accumulation, still compare
// R07 - accumulate mode: add, shift, compare each
// R08 - accumulator and filtered value right-justified
// R09 - average mode compares once count reaches target
// R10 - burst mode retriggers until count reaches target
// R11 - low-pass mode filters, compares after target
// R12 - six error formulas chosen by select
// R13 - error sets upper and lower flags
// R14 - eight threshold conditions set threshold flag
// R15 - threshold comparisons are signed
// R16 - overflow forces threshold flag
// R17 - continuous mode keeps go set, retriggers
// R18 - stop-on-flag clears go bit
// R19 - double sampling needs two conversions
// R20 - first half sets flag, no error
// R21 - second half moves previous, computes error
// R22 - double sampling accumulates the difference
// R23 - sample counter saturates at ff
// R24 - average mode clears accumulator after tested set
// R25 - burst mode clears accumulator at each trigger
// R26 - low-pass keeps testing after target reached
package arc_pkg;
	// data widths
	localparam int ACC_W = 18;
	localparam int RES_W = 12;
	localparam int DAT_W = 16;
	localparam int ERR_W = 17;
	localparam logic [ACC_W-1:0] ACC_MAX = 18'h3ffff;
	localparam logic [7:0] CNT_MAX = 8'hff;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_RPT = 8'h08;
	localparam logic [7:0] OFF_CNT = 8'h0c;
	localparam logic [7:0] OFF_ACC = 8'h10;
	localparam logic [7:0] OFF_FLT = 8'h14;
	localparam logic [7:0] OFF_ERR = 8'h18;
	localparam logic [7:0] OFF_STPT = 8'h1c;
	localparam logic [7:0] OFF_UTH = 8'h20;
	localparam logic [7:0] OFF_LTH = 8'h24;
	localparam logic [7:0] OFF_RES = 8'h28;
	localparam logic [7:0] OFF_PREV = 8'h2c;
	// control register bits and field lsbs
	localparam int CB_GO = 0;
	localparam int CB_AUTO_RETRIGGER_ENABLE = 1;
	localparam int CB_SOI = 2;
	localparam int CB_DOUBLE_SAMPLE_ENABLE = 3;
	localparam int CB_CLR = 4;
	localparam int CB_PREVIOUS_SOURCE_SELECT = 5;
	localparam int CF_MD = 8;
	localparam int CF_CRS = 12;
	localparam int CF_ERROR_FORMULA_SELECT = 16;
	localparam int CF_TMD = 20;
	// status register bits
	localparam int SB_AOV = 0;
	localparam int SB_UPPER_COMPARE_FLAG = 1;
	localparam int SB_LOWER_COMPARE_FLAG = 2;
	localparam int SB_FIRST_HALF_DONE_FLAG = 3;
	localparam int SB_TIF = 4;
	// accumulator clear duration
	localparam int CLK_NS = 10;
	localparam int CLR_TIME_NS = 30;
	localparam int CLR_CYC = (CLR_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [2:0] CLR_LOAD = 3'(CLR_CYC - 1);
	// computation modes
	typedef enum logic [2:0] {
		MD_BASIC = 3'b000,
		MD_ACCUM = 3'b001,
		MD_AVG = 3'b010,
		MD_BURST = 3'b011,
		MD_LPF = 3'b100
	} arc_mode_t;
	// error formulas
	typedef enum logic [2:0] {
		ERROR_FORMULA_SELECT_SDIFF = 3'b000,
		ERROR_FORMULA_SELECT_CVD = 3'b001,
		ERROR_FORMULA_SELECT_RSTP = 3'b010,
		ERROR_FORMULA_SELECT_RFLT = 3'b011,
		ERROR_FORMULA_SELECT_FDIFF = 3'b100,
		ERROR_FORMULA_SELECT_FSTP = 3'b101
	} arc_error_formula_select_t;
	// conversion sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_WAIT = 2'b10
	} arc_state_t;
	// result delivered by the conversion core
	typedef struct packed {
		logic done;
		logic [RES_W-1:0] data;
	} arc_conv_t;
endpackage

/* arc_core.sv */
// result computation unit: accumulator, filter, error and threshold test
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
module arc_core (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// conversion core
	input arc_pkg::arc_conv_t conv,
	output logic convStart,
	output logic convGo,
	// threshold flag level
	output logic thresholdIrqFlag
);
	// go and the clear command are also written by hardware, so the
	// software write and the hardware updates meet in one next-value
	// process and the word keeps a single driver
	// layout: go, continuous, stop-on-flag, double sample, clear,
	// previous source, then mode, shift, formula and threshold mode
	// software control word
	logic [31:0] ctrl_r;
	logic [31:0] ctrl_nxt;
	// user registers
	logic [7:0] repeatTarget_r;
	logic [15:0] setpointValue_r;
	logic [15:0] upperThreshold_r;
	logic [15:0] lowerThreshold_r;
	// computed state
	logic [arc_pkg::ACC_W-1:0] accumulatorValue_r;
	logic [7:0] sampleCounter_r;
	logic accumOverflowFlag_r;
	logic [arc_pkg::DAT_W-1:0] filteredResult_r;
	logic [arc_pkg::ERR_W-1:0] errorValue_r;
	logic [arc_pkg::RES_W-1:0] conversionResult_r;
	logic [arc_pkg::DAT_W-1:0] previousResult_r;
	logic [arc_pkg::RES_W-1:0] firstSample_r;
	logic firstHalfDoneFlag_r;
	logic upperCompareFlag_r;
	logic lowerCompareFlag_r;
	logic tif_r;
	logic burstRun_r;
	logic [2:0] clrCnt_r;
	arc_pkg::arc_state_t state_r;
	arc_pkg::arc_state_t state_nxt;

	// control fields
	wire goBit = ctrl_r[arc_pkg::CB_GO];
	wire autoRetriggerEnable = ctrl_r[arc_pkg::CB_AUTO_RETRIGGER_ENABLE];
	wire stopOnIrq = ctrl_r[arc_pkg::CB_SOI];
	wire doubleSampleEnable = ctrl_r[arc_pkg::CB_DOUBLE_SAMPLE_ENABLE];
	wire accumClearCmd = ctrl_r[arc_pkg::CB_CLR];
	wire previousSourceSelect = ctrl_r[arc_pkg::CB_PREVIOUS_SOURCE_SELECT];
	wire [2:0] computeModeSelect = ctrl_r[arc_pkg::CF_MD +: 3];
	wire [2:0] shiftAmount = ctrl_r[arc_pkg::CF_CRS +: 3];
	wire [2:0] errorFormulaSelect = ctrl_r[arc_pkg::CF_ERROR_FORMULA_SELECT +: 3];
	wire [2:0] thresholdModeSelect = ctrl_r[arc_pkg::CF_TMD +: 3];

	// mode decode
	wire modeBasic = computeModeSelect == arc_pkg::MD_BASIC;
	wire modeAvg = computeModeSelect == arc_pkg::MD_AVG;
	wire modeBurst = computeModeSelect == arc_pkg::MD_BURST;
	wire modeLpf = computeModeSelect == arc_pkg::MD_LPF;
	wire modeAccum = computeModeSelect == arc_pkg::MD_ACCUM;
	// an illegal mode code behaves like basic: no accumulation
	wire modeSums = modeAccum | modeAvg | modeBurst | modeLpf;

	// apb decode
	wire apbSetup = psel & ~penable;
	wire apbAccess = psel & penable;
	wire apbWrite = apbAccess & pwrite;
	wire selCtrl = paddr == arc_pkg::OFF_CTRL;
	wire selStat = paddr == arc_pkg::OFF_STAT;
	wire selRpt = paddr == arc_pkg::OFF_RPT;
	wire selCnt = paddr == arc_pkg::OFF_CNT;
	wire selAcc = paddr == arc_pkg::OFF_ACC;
	wire selFlt = paddr == arc_pkg::OFF_FLT;
	wire selErr = paddr == arc_pkg::OFF_ERR;
	wire selStpt = paddr == arc_pkg::OFF_STPT;
	wire selUth = paddr == arc_pkg::OFF_UTH;
	wire selLth = paddr == arc_pkg::OFF_LTH;
	wire selRes = paddr == arc_pkg::OFF_RES;
	wire selPrev = paddr == arc_pkg::OFF_PREV;
	wire addrHit = selCtrl | selStat | selRpt | selCnt | selAcc | selFlt | selErr |
		selStpt | selUth | selLth | selRes | selPrev;
	wire wrCtrl = apbWrite & selCtrl;
	wire wrStat = apbWrite & selStat;

	// clear sequencing: the count runs while the command bit stands
	wire clearing = accumClearCmd;
	wire clearLast = clearing & (clrCnt_r == '0);

	// conversion completion and double-sample phase
	wire doneEv = conv.done & (state_r == arc_pkg::ST_WAIT);
	wire firstHalf = doubleSampleEnable & ~firstHalfDoneFlag_r;
	wire processEv = doneEv & ~firstHalf;
	wire accumEv = processEv & modeSums;

	// the accumulator path works in 20 signed bits: two guard bits
	// above the 18-bit accumulator let a carry out show as overflow
	// and a negative double-sample difference stay negative; only the
	// low 18 bits are kept, so the stored sum wraps after an overflow
	// and software must check the overflow flag before trusting it
	// accumulated sample: plain result, or second minus first
	wire signed [13:0] sampleVal = doubleSampleEnable ?
		$signed({2'b00, conv.data}) - $signed({2'b00, firstSample_r}) :
		$signed({2'b00, conv.data}); // R22
	wire signed [19:0] sampleExt = 20'(sampleVal);
	wire signed [19:0] accExt = $signed({2'b00, accumulatorValue_r});
	wire [arc_pkg::ACC_W-1:0] accShifted = accumulatorValue_r >> shiftAmount;
	// low-pass feeds back acc minus acc/2^shift, others plain sum
	wire signed [19:0] lpfBase = accExt - $signed({2'b00, accShifted}); // R11
	wire signed [19:0] sumVal = (modeLpf ? lpfBase : accExt) + sampleExt; // R01
	wire sumOver = ~sumVal[19] & sumVal[18]; // R01
	wire [arc_pkg::ACC_W-1:0] accNew = sumVal[arc_pkg::ACC_W-1:0];
	wire [arc_pkg::ACC_W-1:0] accNewShift = accNew >> shiftAmount; // R05
	// right-justified whatever the result format elsewhere
	wire [arc_pkg::DAT_W-1:0] fltNew = accNewShift[arc_pkg::DAT_W-1:0]; // R08
	wire [arc_pkg::DAT_W-1:0] fltUse = accumEv ? fltNew : filteredResult_r;
	wire [7:0] cntNew = (sampleCounter_r == arc_pkg::CNT_MAX) ?
		sampleCounter_r : sampleCounter_r + 8'h01; // R23
	wire [7:0] cntUse = accumEv ? cntNew : sampleCounter_r;
	wire aovUse = accumOverflowFlag_r | (accumEv & sumOver);

	// previous value: first conversion, last result, or filtered value
	wire [arc_pkg::DAT_W-1:0] prevNew = previousSourceSelect ? filteredResult_r :
		doubleSampleEnable ? {4'h0, firstSample_r} : {4'h0, conversionResult_r}; // R21

	// setpoint and thresholds are signed 16-bit words, sign-extended
	// to 17 bits; results and filtered values are unsigned and get a
	// zero top bit; a large filtered value minus a very negative
	// setpoint can still wrap, so keep the shift suited to the count
	// error operands, all signed 17 bits
	wire signed [arc_pkg::ERR_W-1:0] resOp = $signed({5'h00, conv.data});
	wire signed [arc_pkg::ERR_W-1:0] prevOp = $signed({1'b0, prevNew});
	wire signed [arc_pkg::ERR_W-1:0] fltOp = $signed({1'b0, fltUse});
	wire signed [arc_pkg::ERR_W-1:0] stpOp = $signed({setpointValue_r[15], setpointValue_r});
	wire signed [arc_pkg::ERR_W-1:0] uthOp = $signed({upperThreshold_r[15], upperThreshold_r});
	wire signed [arc_pkg::ERR_W-1:0] lthOp = $signed({lowerThreshold_r[15], lowerThreshold_r});
	logic signed [arc_pkg::ERR_W-1:0] errNew;

	// formula select
	always_comb begin
		unique case (errorFormulaSelect)
			arc_pkg::ERROR_FORMULA_SELECT_SDIFF: errNew = resOp - prevOp; // R12
			arc_pkg::ERROR_FORMULA_SELECT_CVD: errNew = resOp - prevOp;
			arc_pkg::ERROR_FORMULA_SELECT_RSTP: errNew = resOp - stpOp;
			arc_pkg::ERROR_FORMULA_SELECT_RFLT: errNew = resOp - fltOp;
			arc_pkg::ERROR_FORMULA_SELECT_FDIFF: errNew = fltOp - prevOp;
			arc_pkg::ERROR_FORMULA_SELECT_FSTP: errNew = fltOp - stpOp;
			// unused codes give a zero error
			default: errNew = '0;
		endcase
	end

	// signed comparisons against both thresholds
	wire aboveUpper = errNew > uthOp; // R15
	wire belowLower = errNew < lthOp; // R15
	logic condMet;

	// threshold mode select
	always_comb begin
		unique case (thresholdModeSelect)
			3'b000: condMet = 1'b0; // R14
			3'b001: condMet = belowLower;
			3'b010: condMet = ~belowLower;
			3'b011: condMet = ~belowLower & ~aboveUpper;
			3'b100: condMet = belowLower | aboveUpper;
			3'b101: condMet = ~aboveUpper;
			3'b110: condMet = aboveUpper;
			3'b111: condMet = 1'b1;
		endcase
	end

	// test gating: every sample in basic/accumulate, else after target
	wire countReached = cntUse >= repeatTarget_r; // R09
	wire testEn = processEv & ((modeBasic | modeAccum | ~modeSums) | countReached); // R06 R07
	// overflow forces the flag so handlers can judge the result
	wire tifSet = testEn & (condMet | aovUse); // R14 R16

	// retrigger after an update: continuous, or burst short of target except after a first half
	wire burstMore = modeBurst & (cntUse < repeatTarget_r); // R10
	wire retrig = autoRetriggerEnable | (burstMore & ~firstHalf); // R17 R19
	wire soiStop = stopOnIrq & tifSet; // R18
	wire goAfter = retrig & ~soiStop;

	// pre-clear at conversion start: finished average set, new burst
	wire startEv = state_r == arc_pkg::ST_START;
	wire avgClr = modeAvg & (sampleCounter_r >= repeatTarget_r); // R24
	wire burstClr = modeBurst & ~burstRun_r; // R25
	wire preClr = startEv & ~firstHalfDoneFlag_r & (avgClr | burstClr);

	// at the end of a conversion hardware decides whether go stays
	// set, and that decision wins over a software write in the same
	// cycle, so a trigger written right at a result may be lost;
	// the trade keeps retrigger and stop-on-flag free of races
	// control word: software write, then hardware go/clear updates
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wrCtrl) begin
			ctrl_nxt = pwdata;
		end
		if (doneEv) begin
			// hardware owns go at the end of a conversion
			ctrl_nxt[arc_pkg::CB_GO] = goAfter; // R17 R18
		end
		if (clearLast & ~(wrCtrl & pwdata[arc_pkg::CB_CLR])) begin
			// a new write of the command bit wins over completion
			ctrl_nxt[arc_pkg::CB_CLR] = 1'b0; // R03
		end
	end

	// one conversion in flight at most: idle waits for go, start lasts
	// a single cycle and raises the start pulse, and wait ignores
	// everything until the core reports a result
	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			arc_pkg::ST_IDLE: begin
				// hold off while a clear is in progress
				if (goBit & ~clearing) begin
					state_nxt = arc_pkg::ST_START;
				end
			end
			arc_pkg::ST_START: state_nxt = arc_pkg::ST_WAIT;
			arc_pkg::ST_WAIT: begin
				if (conv.done) begin
					state_nxt = arc_pkg::ST_IDLE;
				end
			end
			default: state_nxt = arc_pkg::ST_IDLE;
		endcase
	end

	// control, sequencer and clear counter
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= '0;
			state_r <= arc_pkg::ST_IDLE;
			clrCnt_r <= arc_pkg::CLR_LOAD;
		end else begin
			ctrl_r <= ctrl_nxt;
			state_r <= state_nxt;
			// count down while clearing, reload otherwise
			clrCnt_r <= (clearing & ~clearLast) ? clrCnt_r - 3'h1 : arc_pkg::CLR_LOAD; // R04
		end
	end

	// repeat target, setpoint and thresholds are plain software
	// registers; a change in mid-set takes effect at the next test
	// user setting registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			repeatTarget_r <= '0;
			setpointValue_r <= '0;
			upperThreshold_r <= '0;
			lowerThreshold_r <= '0;
		end else if (apbWrite) begin
			if (selRpt) repeatTarget_r <= pwdata[7:0]; // R02
			if (selStpt) setpointValue_r <= pwdata[15:0];
			if (selUth) upperThreshold_r <= pwdata[15:0];
			if (selLth) lowerThreshold_r <= pwdata[15:0];
		end
	end

	// accumulator, counter and overflow; clear has priority
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			accumulatorValue_r <= '0;
			sampleCounter_r <= '0;
			accumOverflowFlag_r <= 1'b0;
			filteredResult_r <= '0;
		end else if (clearLast | preClr) begin
			accumulatorValue_r <= '0; // R03 R24 R25
			sampleCounter_r <= '0;
			accumOverflowFlag_r <= 1'b0;
		end else if (accumEv) begin
			accumulatorValue_r <= accNew; // R07 R26
			sampleCounter_r <= cntNew; // R02
			accumOverflowFlag_r <= aovUse; // R01
			filteredResult_r <= fltNew; // R05
		end
	end

	// result, previous, first sample and double-sample phase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			conversionResult_r <= '0;
			previousResult_r <= '0;
			firstSample_r <= '0;
			firstHalfDoneFlag_r <= 1'b0;
			burstRun_r <= 1'b0;
		end else if (doneEv & firstHalf) begin
			// first of a pair: hold it, no error or flag yet
			firstSample_r <= conv.data; // R20
			firstHalfDoneFlag_r <= 1'b1; // R19 R20
		end else if (processEv) begin
			previousResult_r <= prevNew; // R21
			conversionResult_r <= conv.data; // R21
			firstHalfDoneFlag_r <= 1'b0;
			burstRun_r <= burstMore & goAfter; // R10
		end
	end

	// error value and comparison flags, updated on each test
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			errorValue_r <= '0;
			upperCompareFlag_r <= 1'b0;
			lowerCompareFlag_r <= 1'b0;
		end else if (testEn) begin
			errorValue_r <= errNew; // R12
			upperCompareFlag_r <= aboveUpper; // R13
			lowerCompareFlag_r <= belowLower; // R13
		end
	end

	// the flag stays set until software writes a one to it; a test
	// that sets it in the same cycle wins, so no event is lost
	// sticky threshold flag: write one clears, a new set wins
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tif_r <= 1'b0;
		end else if (tifSet) begin
			tif_r <= 1'b1; // R14
		end else if (wrStat & pwdata[arc_pkg::SB_TIF]) begin
			tif_r <= 1'b0;
		end
	end

	// unused high bits read zero except in the control word, which reads back as written; the error value is the only register
	// sign-extended to the full word, setpoint and thresholds read zero-filled
	// read data assembly
	wire [31:0] statWord = {27'h0, tif_r, firstHalfDoneFlag_r, lowerCompareFlag_r,
		upperCompareFlag_r, accumOverflowFlag_r};
	wire [31:0] rdMux =
		selCtrl ? ctrl_r :
		selStat ? statWord :
		selRpt ? {24'h0, repeatTarget_r} :
		selCnt ? {24'h0, sampleCounter_r} :
		selAcc ? {14'h0, accumulatorValue_r} :
		selFlt ? {16'h0, filteredResult_r} :
		selErr ? {{15{errorValue_r[16]}}, errorValue_r} :
		selStpt ? {16'h0, setpointValue_r} :
		selUth ? {16'h0, upperThreshold_r} :
		selLth ? {16'h0, lowerThreshold_r} :
		selRes ? {20'h0, conversionResult_r} :
		selPrev ? {16'h0, previousResult_r} : 32'h0;

	// capturing at setup keeps the read path off the access cycle;
	// the cost is that a value changing in the access cycle itself
	// is seen only by the next read
	// read data captured in the setup cycle; zero-wait access
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= '0;
		end else if (apbSetup & ~pwrite) begin
			prdata <= rdMux;
		end
	end

	// outputs
	assign pready = 1'b1;
	assign pslverr = apbAccess & ~addrHit;
	assign convStart = startEv;
	assign convGo = goBit;
	assign thresholdIrqFlag = tif_r;
endmodule

/* arc_core_props.sv */
// assertion checker for the result computation block ports
`timescale 1ns/10ps
module arc_core_props (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// apb side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// conversion side and flag
	input arc_pkg::arc_conv_t conv,
	input wire logic convStart,
	input wire logic convGo,
	input wire logic thresholdIrqFlag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic ctrlWr; // control write at its access edge
	logic statWr; // status write at its access edge
	assign ctrlWr = psel && penable && pwrite && paddr == arc_pkg::OFF_CTRL;
	assign statWr = psel && penable && pwrite && paddr == arc_pkg::OFF_STAT;
	a_start_one_pulse: assert property (convStart |=> !convStart)
		else $error("start held longer than one cycle");
	a_start_needs_go: assert property (convStart |-> $past(convGo))
		else $error("start without go");
	a_go_starts_soon: assert property ($rose(convGo) |-> ##[1:6] convStart)
		else $error("go set but no start");
	a_done_gap_kept: assert property (conv.done |=> !convStart)
		else $error("start right after a result");
	a_go_set_cause: assert property ($rose(convGo) |-> $past(ctrlWr && pwdata[0]))
		else $error("go set without a write");
	a_go_clear_cause: assert property ($fell(convGo) |-> $past(conv.done || ctrlWr))
		else $error("go cleared without cause");
	a_flag_set_cause: assert property ($rose(thresholdIrqFlag) |-> $past(conv.done))
		else $error("flag set without a result");
	a_flag_sticky: assert property ($fell(thresholdIrqFlag) |-> $past(statWr && pwdata[4]))
		else $error("flag dropped without a write");
	a_unmapped_error: assert property (psel && penable && paddr > 8'h2c |-> pslverr)
		else $error("unmapped access not refused");
endmodule
bind arc_core arc_core_props chk_u (.clk(clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .conv(conv), .convStart(convStart),
	.convGo(convGo), .thresholdIrqFlag(thresholdIrqFlag));

/* arc_conv_model.sv */
// behavioural conversion core answering each start after a set delay
`timescale 1ns/10ps
module arc_conv_model (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// start request and bench controls
	input wire logic convStart,
	input wire logic [11:0] sampleVal,
	input wire logic [7:0] latency,
	// result towards the block
	output arc_pkg::arc_conv_t conv
);
	logic [7:0] waitCnt; // cycles left in the conversion
	logic busy; // one conversion in flight
	logic fin; // conversion ends this cycle
	assign fin = busy && waitCnt == 8'h0;
	// data toggles outside done so a stale value never passes as a result
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			waitCnt <= 8'h0;
			conv <= '0;
		end else begin
			conv.done <= fin;
			conv.data <= fin ? sampleVal : ~conv.data;
			if (convStart) begin
				busy <= 1'b1;
				waitCnt <= latency;
			end else if (fin) begin
				busy <= 1'b0;
			end else if (busy) begin
				waitCnt <= waitCnt - 8'h1;
			end
		end
	end
endmodule

/* arc_core_tb.sv */
// self-checking bench for the result computation block
`timescale 1ns/10ps
module arc_core_tb;
	// one ordinary case: settings, sample, expected results
	typedef struct packed {
		logic [2:0] md, shift_amount, error_formula_select, threshold_mode_select;
		logic [7:0] repeat_target_alias, n;
		logic [11:0] smp;
		logic [31:0] acc, flt, cnt, err;
		logic tif;
	} arc_row_t;
	logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h0, latency = 8'h2;
	logic [31:0] pwdata = 32'h0, prdata, rd, ctl;
	logic [11:0] sampleVal = 12'h0;
	logic pready, pslverr, convStart, convGo, thresholdIrqFlag, slv;
	arc_pkg::arc_conv_t conv;
	int num_errors = 0, cmp_count = 0;
	arc_row_t rows [6];
	always #5 clk = ~clk;
	arc_core dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conv(conv), .convStart(convStart), .convGo(convGo),
		.thresholdIrqFlag(thresholdIrqFlag));
	arc_conv_model conv_u (.clk(clk), .reset_n(reset_n), .convStart(convStart),
		.sampleVal(sampleVal), .latency(latency), .conv(conv));
	// compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// clear command, then poll until hardware drops it
	task automatic clear_acc(input logic [31:0] c);
		int k;
		k = 0;
		apb(1'b1, arc_pkg::OFF_CTRL, c | 32'h10);
		do begin
			apb(1'b0, arc_pkg::OFF_CTRL, 32'h0);
			k++;
		end while (rd[arc_pkg::CB_CLR] !== 1'b0 && k < 9);
		check(32'(k <= 2), 32'h1);
		apb(1'b1, arc_pkg::OFF_STAT, 32'h10);
	endtask
	// software trigger, then wait for go to fall
	task automatic run(input logic [31:0] c);
		int t;
		t = 0;
		apb(1'b1, arc_pkg::OFF_CTRL, c | 32'h1);
		@(posedge clk);
		while (convGo !== 1'b0 && t < 3000) begin
			@(posedge clk);
			t++;
		end
		// a conversion that never ends is a failure, not a silent skip
		if (t >= 3000) begin
			num_errors++;
			$display("run timed out at %0t", $time);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog far beyond the expected run length
	initial begin
		#200000;
		num_errors++;
		wrap_up();
	end
	initial begin
		// setpoint 50, upper 20, lower 0
		rows[0] = '{3'h0, 3'h0, 3'h2, 3'h0, 8'h1, 8'h2, 12'h080, 32'h0, 32'h0, 32'h0, 32'h30, 1'b0};
		rows[1] = '{3'h1, 3'h2, 3'h3, 3'h6, 8'h1, 8'h3, 12'h100, 32'h300, 32'hc0, 32'h3, 32'h40, 1'b1};
		rows[2] = '{3'h2, 3'h2, 3'h5, 3'h1, 8'h4, 8'h4, 12'h040, 32'h100, 32'h40, 32'h4,
			32'hfffffff0, 1'b1};
		rows[3] = '{3'h3, 3'h2, 3'h5, 3'h2, 8'h4, 8'h1, 12'h040, 32'h100, 32'h40, 32'h4,
			32'hfffffff0, 1'b0};
		rows[4] = '{3'h4, 3'h1, 3'h2, 3'h7, 8'h2, 8'h2, 12'h100, 32'h180, 32'hc0, 32'h2, 32'hb0, 1'b1};
		// filtered minus previous, inside-thresholds test at the lower edge
		rows[5] = '{3'h1, 3'h1, 3'h4, 3'h3, 8'h1, 8'h2, 12'h040, 32'h80, 32'h40, 32'h2, 32'h0, 1'b1};
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		apb(1'b1, arc_pkg::OFF_STPT, 32'h50);
		apb(1'b1, arc_pkg::OFF_UTH, 32'h20);
		apb(1'b1, arc_pkg::OFF_LTH, 32'h0);
		foreach (rows[i]) begin
			ctl = {9'h0, rows[i].threshold_mode_select, 1'b0, rows[i].error_formula_select, 1'b0, rows[i].shift_amount, 1'b0, rows[i].md, 8'h0};
			latency <= 8'(2 + 3 * i);
			sampleVal <= rows[i].smp;
			apb(1'b1, arc_pkg::OFF_RPT, 32'(rows[i].repeat_target_alias));
			clear_acc(ctl);
			repeat (rows[i].n) run(ctl);
			expect_reg(arc_pkg::OFF_ACC, rows[i].acc);
			expect_reg(arc_pkg::OFF_FLT, rows[i].flt);
			expect_reg(arc_pkg::OFF_CNT, rows[i].cnt);
			expect_reg(arc_pkg::OFF_ERR, rows[i].err);
			apb(1'b0, arc_pkg::OFF_STAT, 32'h0);
			check(32'(rd[4]), 32'(rows[i].tif));
			check(32'(thresholdIrqFlag), 32'(rows[i].tif));
			$display("row %0d done", i);
		end
		// long continuous run: counter saturates, sum overflows, flag forced
		sampleVal <= 12'hfff;
		latency <= 8'h1;
		clear_acc(32'h100);
		apb(1'b1, arc_pkg::OFF_CTRL, 32'h103);
		repeat (2200) @(posedge clk);
		run(32'h100);
		expect_reg(arc_pkg::OFF_CNT, 32'hff);
		apb(1'b0, arc_pkg::OFF_STAT, 32'h0);
		check(32'(rd[0]), 32'h1);
		check(32'(rd[4]), 32'h1);
		clear_acc(32'h100);
		expect_reg(arc_pkg::OFF_ACC, 32'h0);
		expect_reg(arc_pkg::OFF_STAT, 32'h0);
		$display("overflow test done");
		// double sampling: two software triggers, difference accumulated
		sampleVal <= 12'h100;
		run(32'h710108);
		apb(1'b0, arc_pkg::OFF_STAT, 32'h0);
		check(32'(rd[4:3]), 32'h1);
		sampleVal <= 12'h300;
		run(32'h710108);
		expect_reg(arc_pkg::OFF_PREV, 32'h100);
		expect_reg(arc_pkg::OFF_RES, 32'h300);
		expect_reg(arc_pkg::OFF_ACC, 32'h200);
		apb(1'b0, arc_pkg::OFF_STAT, 32'h0);
		check(32'(rd[4]), 32'h1);
		apb(1'b0, 8'h30, 32'h0);
		check({31'h0, slv}, 32'h1);
		check(rd, 32'h0);
		$display("double sample and unmapped tests done");
		// continuous run with stop on flag: one sample, then go falls
		clear_acc(32'h620100);
		run(32'h620106);
		expect_reg(arc_pkg::OFF_CNT, 32'h1);
		expect_reg(arc_pkg::OFF_ERR, 32'h2b0);
		expect_reg(arc_pkg::OFF_STAT, 32'h12);
		$display("stop on flag test done");
		// reset after the stop-on-flag run returns control, sum and flag to zero
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		check(32'(thresholdIrqFlag), 32'h0);
		expect_reg(arc_pkg::OFF_CTRL, 32'h0);
		expect_reg(arc_pkg::OFF_ACC, 32'h0);
		$display("reset test done");
		wrap_up();
	end
endmodule
